// [logic/dual_timer_mode_control.sv]
// Two timer/counters, their mode and control registers, two external interrupts
// Assumes an APB master on clk; pins and vector acks synchronous to clk
// Contract
// - Timer 0 overflow sets its flag
// - Vectoring clears the timer overflow flag
// - Timer 1 gating by run and pin; while timer 0 is split, timer 1 runs without its run bit
// - Timer 1 counts clock or pin falls
// - Interrupt type selects level or edge
// - Flag set on detect, edge flag auto-cleared
// - Mode register holds both timer nibbles
// - Mode 0 is prescaled 8-bit counter
// - Mode 1 is cascaded 16-bit counter
// - Mode 2 reloads low from high
// - Timer 0 split mode, two 8-bit timers
// - Timer 1 mode 3 holds its count
// - Mode 0 prescaler is five low bits
// - Reload leaves high byte, writable anytime
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "timer_defs_defs.svh"
module dual_timer_mode_control #(
    parameter int CLK_DIV = `TMR_CLK_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire logic ext_irq0_pin_n,
    input wire logic ext_irq1_pin_n,
    input wire logic t0_count_pin,
    input wire logic t1_count_pin,
    // Processor vectoring
    input wire logic t0_vector_ack,
    input wire logic t1_vector_ack,
    input wire logic ext_irq0_ack,
    input wire logic ext_irq1_ack,
    // Flags and interrupt
    output logic t0_overflow_flag,
    output logic t1_overflow_flag,
    output logic ext_irq0_flag,
    output logic ext_irq1_flag,
    output logic irq
);
    logic [7:0] control_reg, control_next;
    logic [7:0] timer_mode_reg, timer_mode_next;
    logic t0f_reg, t0f_next, t1f_reg, t1f_next;
    logic [3:0] status_reg, status_next, mask_reg, mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] div_reg, div_next;
    logic pin0_reg, pin1_reg;
    logic [7:0] t0_low, t0_high, t1_low, t1_high;
    logic t0_ovf, t0_ovf_hi, t1_ovf, x0_event, x1_event;
    timer_pkg::timer_field_t t0_field, t1_field;
    timer_pkg::count_write_t t0_wr, t1_wr;

    // Address decode
    wire [9:0] idx = paddr[11:2];
    wire sel_control = idx == `TMR_IDX_CONTROL;
    wire sel_mode = idx == `TMR_IDX_MODE;
    wire sel_t0_lo = idx == `TMR_IDX_T0_LOW;
    wire sel_t1_lo = idx == `TMR_IDX_T1_LOW;
    wire sel_t0_hi = idx == `TMR_IDX_T0_HIGH;
    wire sel_t1_hi = idx == `TMR_IDX_T1_HIGH;
    wire sel_status = idx == `TMR_IDX_IRQ_STATUS;
    wire sel_mask = idx == `TMR_IDX_IRQ_MASK;
    wire mapped = sel_control | sel_mode | sel_t0_lo | sel_t1_lo | sel_t0_hi | sel_t1_hi | sel_status | sel_mask;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr_en = access & pwrite & mapped;
    wire wr_control = wr_en & sel_control;
    wire wr_mode = wr_en & sel_mode;
    wire wr_status = wr_en & sel_status;
    wire wr_mask = wr_en & sel_mask;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // Mode fields
    assign t1_field = timer_pkg::timer_field_t'(timer_mode_reg[`MODE_T1_LSB +: 4]);
    assign t0_field = timer_pkg::timer_field_t'(timer_mode_reg[`MODE_T0_LSB +: 4]);
    wire split0 = t0_field.mode == timer_pkg::MODE_SPLIT;
    wire hold1 = t1_field.mode == timer_pkg::MODE_SPLIT;
    wire t0_run = control_reg[`CTL_T0_RUN];
    wire t1_run = control_reg[`CTL_T1_RUN];

    // Clock divider
    wire div_tick = div_reg == 8'(CLK_DIV - 1);
    assign div_next = div_tick ? 8'h00 : div_reg + 8'h01;

    // Count pin falling edges
    wire t0_pin_fall = pin0_reg & ~t0_count_pin;
    wire t1_pin_fall = pin1_reg & ~t1_count_pin;

    // Count enables
    wire t0_src = t0_field.source_select ? t0_pin_fall : div_tick;
    wire t1_src = t1_field.source_select ? t1_pin_fall : div_tick;
    wire t0_gate_ok = ~t0_field.gating | ext_irq0_pin_n;
    wire t1_gate_ok = ~t1_field.gating | ext_irq1_pin_n;
    wire t1_run_eff = split0 | t1_run;
    wire t0_tick = t0_run & t0_gate_ok & t0_src;
    wire t0_tick_hi = split0 & t1_run & div_tick;
    wire t1_tick = t1_run_eff & t1_gate_ok & t1_src & ~hold1;

    // Counter writes
    assign t0_wr = {wr_en & sel_t0_lo, wr_en & sel_t0_hi, pwdata[7:0]};
    assign t1_wr = {wr_en & sel_t1_lo, wr_en & sel_t1_hi, pwdata[7:0]};

    timer_core u_timer0 (
        .clk(clk),
        .rst_n(rst_n),
        .mode(t0_field.mode),
        .tick(t0_tick),
        .tick_hi(t0_tick_hi),
        .sw_write(t0_wr),
        .low(t0_low),
        .high(t0_high),
        .ovf(t0_ovf),
        .ovf_hi(t0_ovf_hi)
    );

    timer_core u_timer1 (
        .clk(clk),
        .rst_n(rst_n),
        .mode(t1_field.mode),
        .tick(t1_tick),
        .tick_hi(1'b0),
        .sw_write(t1_wr),
        .low(t1_low),
        .high(t1_high),
        .ovf(t1_ovf),
        .ovf_hi()
    );

    ext_irq_detect u_ext0 (
        .clk(clk),
        .rst_n(rst_n),
        .pin_n(ext_irq0_pin_n),
        .edge_mode(control_reg[`CTL_X0_TYPE]),
        .ack(ext_irq0_ack),
        .sw_write(wr_control),
        .sw_value(pwdata[`CTL_X0_FLAG]),
        .flag(ext_irq0_flag),
        .detect_event(x0_event)
    );

    ext_irq_detect u_ext1 (
        .clk(clk),
        .rst_n(rst_n),
        .pin_n(ext_irq1_pin_n),
        .edge_mode(control_reg[`CTL_X1_TYPE]),
        .ack(ext_irq1_ack),
        .sw_write(wr_control),
        .sw_value(pwdata[`CTL_X1_FLAG]),
        .flag(ext_irq1_flag),
        .detect_event(x1_event)
    );

    // Overflow flags, set wins over clear
    wire t0_set = t0_ovf;
    wire t1_set = split0 ? t0_ovf_hi : t1_ovf;
    assign t0f_next = t0_set | (~t0_vector_ack & (wr_control ? pwdata[`CTL_T0_FLAG] : t0f_reg));
    assign t1f_next = t1_set | (~t1_vector_ack & (wr_control ? pwdata[`CTL_T1_FLAG] : t1f_reg));
    assign control_next = wr_control ? pwdata[7:0] : control_reg;
    assign timer_mode_next = wr_mode ? pwdata[7:0] : timer_mode_reg;

    // Interrupt status and mask
    wire [3:0] events = {x1_event, x0_event, t1_set, t0_set};
    wire [3:0] w1c = wr_status ? pwdata[3:0] : 4'h0;
    assign status_next = (status_reg & ~w1c) | events;
    assign mask_next = wr_mask ? pwdata[3:0] : mask_reg;
    assign irq = |(status_reg & mask_reg);

    // Read data
    wire [7:0] control_value = {t1f_reg, control_reg[`CTL_T1_RUN], t0f_reg, control_reg[`CTL_T0_RUN],
        ext_irq1_flag, control_reg[`CTL_X1_TYPE], ext_irq0_flag, control_reg[`CTL_X0_TYPE]};
    wire [7:0] read_byte = sel_control ? control_value :
        sel_mode ? timer_mode_reg :
        sel_t0_lo ? t0_low :
        sel_t1_lo ? t1_low :
        sel_t0_hi ? t0_high :
        sel_t1_hi ? t1_high :
        sel_status ? {4'h0, status_reg} :
        sel_mask ? {4'h0, mask_reg} : 8'h00;
    assign rdata_next = setup ? {24'h000000, read_byte} : rdata_reg;
    assign prdata = rdata_reg;
    assign t0_overflow_flag = t0f_reg;
    assign t1_overflow_flag = t1f_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            control_reg <= `TMR_CONTROL_RESET;
            timer_mode_reg <= `TMR_MODE_RESET;
            t0f_reg <= 1'b0;
            t1f_reg <= 1'b0;
            status_reg <= 4'h0;
            mask_reg <= 4'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            control_reg <= control_next;
            timer_mode_reg <= timer_mode_next;
            t0f_reg <= t0f_next;
            t1f_reg <= t1f_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
            pin0_reg <= 1'b1;
            pin1_reg <= 1'b1;
        end else begin
            div_reg <= div_next;
            pin0_reg <= t0_count_pin;
            pin1_reg <= t1_count_pin;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    t0_flag_set_a: assert property (t0_ovf |=> t0f_reg)
        else $error("timer 0 overflow did not set flag");

    t1_vector_clear_a: assert property (t1_vector_ack && !t1_set |=> !t1f_reg)
        else $error("timer 1 flag not cleared on vectoring");

    t1_gate_hold_a: assert property (
        t1_field.gating && !ext_irq1_pin_n && !split0 && !t1_wr.wr_lo && !t1_wr.wr_hi
        |=> {t1_high, t1_low} == $past({t1_high, t1_low}))
        else $error("gated timer 1 counted with pin low");

    t1_source_a: assert property (
        t1_field.source_select && !t1_pin_fall |-> !t1_tick)
        else $error("timer 1 counted without a pin fall");

    ext_level_a: assert property (
        !control_reg[`CTL_X0_TYPE] && !wr_control |=> ext_irq0_flag == !$past(ext_irq0_pin_n))
        else $error("level interrupt flag does not follow pin");

    ext_edge_clear_a: assert property (
        control_reg[`CTL_X1_TYPE] && !wr_control && ext_irq1_ack && !x1_event |=> !ext_irq1_flag)
        else $error("edge flag not cleared on processing");

    mode_store_a: assert property (wr_mode |=> timer_mode_reg == $past(pwdata[7:0]))
        else $error("mode register write lost");

    prescale_carry_a: assert property (
        t0_tick && t0_field.mode == timer_pkg::MODE_PRESCALED && &t0_low[4:0]
        && !t0_wr.wr_lo && !t0_wr.wr_hi
        |=> t0_high == 8'($past(t0_high) + 8'h01) && t0_low[7:5] == $past(t0_low[7:5]))
        else $error("prescaler carry missing");

    t1_halt_a: assert property (
        hold1 && !t1_wr.wr_lo && !t1_wr.wr_hi |=> {t1_high, t1_low} == $past({t1_high, t1_low}))
        else $error("timer 1 moved in mode 3");

    split_flag_a: assert property (split0 && t0_ovf_hi |=> t1f_reg)
        else $error("split high byte overflow lost");

    irq_level_a: assert property (|(status_reg & mask_reg) && !wr_mask && !wr_status |=> irq)
        else $error("interrupt output dropped with unmasked status pending");

    t0_vector_clear_a: assert property (
        t0_vector_ack && !t0_set |=> !t0f_reg)
        else $error("timer 0 flag not cleared on vectoring");

    t1_flag_set_a: assert property (
        !split0 && t1_ovf |=> t1f_reg)
        else $error("timer 1 overflow did not set flag");

    status_set_a: assert property (
        t0_set |=> status_reg[`ST_T0_OVF])
        else $error("timer 0 overflow did not set status");

    w1c_clear_a: assert property (
        wr_status && pwdata[`ST_X0] && !x0_event |=> !status_reg[`ST_X0])
        else $error("status bit not cleared by writing one");

    t0_run_stop_a: assert property (
        !t0_run |-> !t0_tick)
        else $error("timer 0 counted with run clear");

    t1_run_stop_a: assert property (
        !t1_run && !split0 |-> !t1_tick)
        else $error("timer 1 counted with run clear");

    t0_gate_block_a: assert property (
        t0_field.gating && !ext_irq0_pin_n |-> !t0_tick)
        else $error("gated timer 0 counted with pin low");

    t0_source_a: assert property (
        t0_field.source_select && !t0_pin_fall |-> !t0_tick)
        else $error("timer 0 counted without a pin fall");

    split_high_a: assert property (
        split0 && t1_run && div_tick && !t0_wr.wr_hi |=> t0_high == 8'($past(t0_high) + 8'h01))
        else $error("split high byte did not count");

    cascade_step_a: assert property (
        t0_tick && t0_field.mode == timer_pkg::MODE_CASCADE && !t0_wr.wr_lo && !t0_wr.wr_hi
        |=> {t0_high, t0_low} == 16'($past({t0_high, t0_low}) + 16'h0001))
        else $error("cascaded count step wrong");

    reload_high_a: assert property (
        t0_field.mode == timer_pkg::MODE_RELOAD && !t0_wr.wr_hi |=> t0_high == $past(t0_high))
        else $error("reload changed the high byte");

    prescale_high_a: assert property (
        t0_tick && t0_field.mode == timer_pkg::MODE_PRESCALED && !(&t0_low[4:0])
        && !t0_wr.wr_lo && !t0_wr.wr_hi |=> t0_high == $past(t0_high))
        else $error("high byte moved without prescaler carry");

    bad_write_a: assert property (
        access && pwrite && !mapped |=> timer_mode_reg == $past(timer_mode_reg) && control_reg == $past(control_reg))
        else $error("unmapped write changed a register");

    read_mode_a: assert property (
        setup && sel_mode |=> prdata[7:0] == $past(timer_mode_reg))
        else $error("mode read data not captured");

    x0_edge_set_a: assert property (
        control_reg[`CTL_X0_TYPE] && x0_event |=> ext_irq0_flag)
        else $error("edge on interrupt 0 did not set flag");

    x1_edge_set_a: assert property (
        control_reg[`CTL_X1_TYPE] && x1_event |=> ext_irq1_flag)
        else $error("edge on interrupt 1 did not set flag");

    split_cov: cover property (split0 && t0_ovf_hi);
    reload_cov: cover property (t1_field.mode == timer_pkg::MODE_RELOAD && t1_ovf);
    edge_cov: cover property (control_reg[`CTL_X0_TYPE] && x0_event ##[1:20] ext_irq0_ack);
    cascade_cov: cover property (t0_field.mode == timer_pkg::MODE_CASCADE && t0_ovf);
    gate_cov: cover property (t1_field.gating && t1_run && !ext_irq1_pin_n);
endmodule : dual_timer_mode_control

// [logic/timer_defs_defs.svh]
// Offsets, field positions, reset values and counts for the dual timer
// Included by the package users; definitions only
`ifndef TIMER_DEFS_DEFS_SVH
`define TIMER_DEFS_DEFS_SVH
// Register indices; byte address is four times the index
`define TMR_IDX_CONTROL 10'h088
`define TMR_IDX_MODE 10'h089
`define TMR_IDX_T0_LOW 10'h08a
`define TMR_IDX_T1_LOW 10'h08b
`define TMR_IDX_T0_HIGH 10'h08c
`define TMR_IDX_T1_HIGH 10'h08d
`define TMR_IDX_IRQ_STATUS 10'h090
`define TMR_IDX_IRQ_MASK 10'h091
// Control register fields
`define CTL_T1_FLAG 7
`define CTL_T1_RUN 6
`define CTL_T0_FLAG 5
`define CTL_T0_RUN 4
`define CTL_X1_FLAG 3
`define CTL_X1_TYPE 2
`define CTL_X0_FLAG 1
`define CTL_X0_TYPE 0
// Mode register fields
`define MODE_T1_LSB 4
`define MODE_T0_LSB 0
// Interrupt status fields
`define ST_T0_OVF 0
`define ST_T1_OVF 1
`define ST_X0 2
`define ST_X1 3
// Reset values and counts
`define TMR_CONTROL_RESET 8'h00
`define TMR_MODE_RESET 8'h00
`define TMR_COUNT_RESET 8'h00
`define TMR_CLK_DIV 6
`define TMR_PRESCALE_BITS 5
`endif

// [logic/timer_pkg.sv]
// Types shared by the dual timer modules
// Assumes nothing of its surroundings
package timer_pkg;
    typedef enum logic [1:0] {MODE_PRESCALED, MODE_CASCADE, MODE_RELOAD, MODE_SPLIT} timer_mode_t;
    typedef struct packed {
        logic gating;
        logic source_select;
        timer_mode_t mode;
    } timer_field_t;
    typedef struct packed {
        logic wr_lo;
        logic wr_hi;
        logic [7:0] wdata;
    } count_write_t;
endpackage : timer_pkg

// [logic/timer_core.sv]
// One 16-bit timer/counter with its four count modes
// Assumes tick pulses already gated by run, gate and source
`timescale 1ns/1ps
`include "timer_defs_defs.svh"
module timer_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input timer_pkg::timer_mode_t mode,
    input wire logic tick,
    input wire logic tick_hi,
    input timer_pkg::count_write_t sw_write,
    // Count and overflow
    output logic [7:0] low,
    output logic [7:0] high,
    output logic ovf,
    output logic ovf_hi
);
    localparam int PB = `TMR_PRESCALE_BITS;
    logic [7:0] low_reg, low_next, high_reg, high_next;
    logic ovf_reg, ovf_next, ovf_hi_reg, ovf_hi_next;
    always_comb begin
        low_next = low_reg;
        high_next = high_reg;
        ovf_next = 1'b0;
        ovf_hi_next = 1'b0;
        if (tick) begin
            unique case (mode)
                timer_pkg::MODE_PRESCALED: begin
                    low_next[PB-1:0] = low_reg[PB-1:0] + 5'h01;
                    if (&low_reg[PB-1:0]) begin
                        high_next = high_reg + 8'h01;
                        ovf_next = &high_reg;
                    end
                end
                timer_pkg::MODE_CASCADE: begin
                    {high_next, low_next} = {high_reg, low_reg} + 16'h0001;
                    ovf_next = &{high_reg, low_reg};
                end
                timer_pkg::MODE_RELOAD: begin
                    low_next = (&low_reg) ? high_reg : low_reg + 8'h01;
                    ovf_next = &low_reg;
                end
                timer_pkg::MODE_SPLIT: begin
                    low_next = low_reg + 8'h01;
                    ovf_next = &low_reg;
                end
            endcase
        end
        if (tick_hi && mode == timer_pkg::MODE_SPLIT) begin
            high_next = high_reg + 8'h01;
            ovf_hi_next = &high_reg;
        end
        if (sw_write.wr_lo) begin
            low_next = sw_write.wdata;
        end
        if (sw_write.wr_hi) begin
            high_next = sw_write.wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_reg <= `TMR_COUNT_RESET;
            high_reg <= `TMR_COUNT_RESET;
            ovf_reg <= 1'b0;
            ovf_hi_reg <= 1'b0;
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
            ovf_reg <= ovf_next;
            ovf_hi_reg <= ovf_hi_next;
        end
    end
    assign low = low_reg;
    assign high = high_reg;
    assign ovf = ovf_reg;
    assign ovf_hi = ovf_hi_reg;
    reload_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick && mode == timer_pkg::MODE_RELOAD && &low_reg && !sw_write.wr_lo && !sw_write.wr_hi
        |=> low_reg == $past(high_reg) && high_reg == $past(high_reg) && ovf_reg)
        else $error("reload did not copy high byte");
endmodule : timer_core

// [logic/ext_irq_detect.sv]
// External interrupt pin detector: low level or falling edge
// Assumes the pin is synchronous to clk
`timescale 1ns/1ps
module ext_irq_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and control
    input wire logic pin_n,
    input wire logic edge_mode,
    input wire logic ack,
    input wire logic sw_write,
    input wire logic sw_value,
    // Flag and event
    output logic flag,
    output logic detect_event
);
    logic prev_reg, flag_reg, flag_next;
    wire fall = prev_reg & ~pin_n;
    wire detect = edge_mode ? fall : ~pin_n;
    always_comb begin
        if (!edge_mode) begin
            flag_next = ~pin_n;
        end else if (detect) begin
            flag_next = 1'b1;
        end else if (ack) begin
            flag_next = 1'b0;
        end else if (sw_write) begin
            flag_next = sw_value;
        end else begin
            flag_next = flag_reg;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= pin_n;
            flag_reg <= flag_next;
        end
    end
    assign flag = flag_reg;
    assign detect_event = fall;
endmodule : ext_irq_detect

// [verif/tb_top.sv]
// Self-checking bench for the dual timer: APB register traffic, modes, pins
// Assumes the design files and timer_defs_defs.svh on the include path
`timescale 1ns/1ps
`include "timer_defs_defs.svh"
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, held;
    logic x0_n, x1_n, c0, c1, v0, v1, a0, a1, t0f, t1f, x0f, x1f, irq;
    int n_errors, n_checks, i;

    dual_timer_mode_control #(.CLK_DIV(2)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq0_pin_n(x0_n), .ext_irq1_pin_n(x1_n),
        .t0_count_pin(c0), .t1_count_pin(c1), .t0_vector_ack(v0), .t1_vector_ack(v1),
        .ext_irq0_ack(a0), .ext_irq1_ack(a1), .t0_overflow_flag(t0f), .t1_overflow_flag(t1f),
        .ext_irq0_flag(x0f), .ext_irq1_flag(x1f), .irq(irq));

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end

    task print_verdict;
        $display("Checks: %0d, errors: %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task chk1(input logic got, input logic exp, input string what);
        check({31'h0, got}, {31'h0, exp}, what);
    endtask : chk1

    // One APB transfer; holds the request until pready is seen high
    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp, "register read");
    endtask : rdchk

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task pulse(input int which);
        @(posedge clk);
        case (which)
            0: v0 <= 1;
            1: v1 <= 1;
            2: a0 <= 1;
            default: a1 <= 1;
        endcase
        @(posedge clk);
        v0 <= 0;
        v1 <= 0;
        a0 <= 0;
        a1 <= 0;
        @(negedge clk);
    endtask : pulse

    task pin_falls(input int n, input logic sel);
        repeat (n) begin
            if (sel) c1 <= 0; else c0 <= 0;
            cyc(3);
            if (sel) c1 <= 1; else c0 <= 1;
            cyc(3);
        end
    endtask : pin_falls

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("Error at %0t: timeout", $time);
        print_verdict;
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, v0, v1, a0, a1} = '0;
        {x0_n, x1_n, c0, c1} = 4'hf;
        n_errors = 0;
        n_checks = 0;
        cyc(2);
        rst_n <= 1;
        // Reset values and unmapped access
        rdchk(`TMR_IDX_CONTROL, 32'h0);
        rdchk(`TMR_IDX_MODE, 32'h0);
        rdchk(`TMR_IDX_T1_HIGH, 32'h0);
        chk1(err, 1'b0, "mapped error");
        apb(1'b0, 10'h0a0, 32'h0);
        chk1(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        wr(10'h0a0, 32'hff);
        chk1(err, 1'b1, "unmapped write error");
        // Mode register layout
        wr(`TMR_IDX_MODE, 32'hffff_ffa5);
        rdchk(`TMR_IDX_MODE, 32'ha5);
        // Timer 0 cascaded 16-bit overflow
        wr(`TMR_IDX_MODE, 32'h01);
        wr(`TMR_IDX_T0_LOW, 32'hfe);
        wr(`TMR_IDX_T0_HIGH, 32'hff);
        rdchk(`TMR_IDX_T0_LOW, 32'hfe);
        wr(`TMR_IDX_CONTROL, 32'h10);
        for (i = 0; i < 100 && t0f !== 1'b1; i++) @(posedge clk);
        @(negedge clk);
        chk1(t0f, 1'b1, "t0 overflow flag");
        rdchk(`TMR_IDX_T0_HIGH, 32'h0);
        pulse(0);
        chk1(t0f, 1'b0, "t0 flag after vector");
        wr(`TMR_IDX_CONTROL, 32'h0);
        apb(1'b0, `TMR_IDX_T0_LOW, 32'h0);
        held = rd;
        cyc(10);
        rdchk(`TMR_IDX_T0_LOW, held);
        // Auto-reload
        wr(`TMR_IDX_MODE, 32'h02);
        wr(`TMR_IDX_T0_HIGH, 32'hf0);
        wr(`TMR_IDX_T0_LOW, 32'hfe);
        wr(`TMR_IDX_CONTROL, 32'h10);
        for (i = 0; i < 100 && t0f !== 1'b1; i++) @(posedge clk);
        chk1(t0f, 1'b1, "reload overflow flag");
        cyc(40);
        wr(`TMR_IDX_CONTROL, 32'h0);
        rdchk(`TMR_IDX_T0_HIGH, 32'hf0);
        apb(1'b0, `TMR_IDX_T0_LOW, 32'h0);
        check({28'h0, rd[7:4]}, 32'hf, "reloaded low");
        // Prescaled mode
        wr(`TMR_IDX_MODE, 32'h00);
        wr(`TMR_IDX_T0_LOW, 32'hff);
        wr(`TMR_IDX_T0_HIGH, 32'h10);
        wr(`TMR_IDX_CONTROL, 32'h10);
        cyc(4);
        wr(`TMR_IDX_CONTROL, 32'h0);
        rdchk(`TMR_IDX_T0_HIGH, 32'h11);
        apb(1'b0, `TMR_IDX_T0_LOW, 32'h0);
        check({29'h0, rd[7:5]}, 32'h7, "prescaler upper bits");
        chk1(rd[4:0] < 5'h08, 1'b1, "prescaler wrap");
        // Timer 1 gating
        x1_n <= 0;
        wr(`TMR_IDX_MODE, 32'h90);
        wr(`TMR_IDX_T1_LOW, 32'h0);
        wr(`TMR_IDX_CONTROL, 32'h40);
        cyc(20);
        rdchk(`TMR_IDX_T1_LOW, 32'h0);
        x1_n <= 1;
        cyc(20);
        wr(`TMR_IDX_CONTROL, 32'h0);
        apb(1'b0, `TMR_IDX_T1_LOW, 32'h0);
        chk1(rd != 32'h0, 1'b1, "gated timer counts");
        // Timer 1 counter source
        wr(`TMR_IDX_MODE, 32'h50);
        wr(`TMR_IDX_T1_LOW, 32'h0);
        wr(`TMR_IDX_CONTROL, 32'h40);
        cyc(12);
        rdchk(`TMR_IDX_T1_LOW, 32'h0);
        pin_falls(3, 1'b1);
        rdchk(`TMR_IDX_T1_LOW, 32'h3);
        // Timer 0 gating and counter source
        wr(`TMR_IDX_CONTROL, 32'h0);
        x0_n <= 0;
        wr(`TMR_IDX_MODE, 32'h09);
        wr(`TMR_IDX_T0_LOW, 32'h0);
        wr(`TMR_IDX_CONTROL, 32'h10);
        cyc(20);
        rdchk(`TMR_IDX_T0_LOW, 32'h0);
        wr(`TMR_IDX_CONTROL, 32'h0);
        x0_n <= 1;
        wr(`TMR_IDX_MODE, 32'h05);
        wr(`TMR_IDX_CONTROL, 32'h10);
        pin_falls(2, 1'b0);
        rdchk(`TMR_IDX_T0_LOW, 32'h2);
        // Split timer 0, timer 1 halted
        wr(`TMR_IDX_CONTROL, 32'h0);
        wr(`TMR_IDX_MODE, 32'h33);
        wr(`TMR_IDX_T0_LOW, 32'h22);
        wr(`TMR_IDX_T0_HIGH, 32'hfe);
        wr(`TMR_IDX_T1_LOW, 32'h55);
        wr(`TMR_IDX_CONTROL, 32'h40);
        for (i = 0; i < 100 && t1f !== 1'b1; i++) @(posedge clk);
        @(negedge clk);
        chk1(t1f, 1'b1, "split high byte overflow");
        chk1(t0f, 1'b0, "t0 flag in split");
        rdchk(`TMR_IDX_T0_LOW, 32'h22);
        rdchk(`TMR_IDX_T1_LOW, 32'h55);
        pulse(1);
        chk1(t1f, 1'b0, "t1 flag after vector");
        wr(`TMR_IDX_CONTROL, 32'h0);
        // External interrupt, edge then level
        wr(`TMR_IDX_IRQ_STATUS, 32'h0f);
        wr(`TMR_IDX_CONTROL, 32'h05);
        {x0_n, x1_n} <= 2'b00;
        cyc(3);
        {x0_n, x1_n} <= 2'b11;
        cyc(2);
        @(negedge clk);
        chk1(x0f, 1'b1, "edge flag");
        chk1(x1f, 1'b1, "edge flag 1");
        pulse(2);
        chk1(x0f, 1'b0, "edge flag after ack");
        chk1(x1f, 1'b1, "edge flag 1 before its ack");
        pulse(3);
        chk1(x1f, 1'b0, "edge flag 1 after ack");
        wr(`TMR_IDX_CONTROL, 32'h0);
        x0_n <= 0;
        cyc(3);
        @(negedge clk);
        chk1(x0f, 1'b1, "level flag");
        pulse(2);
        chk1(x0f, 1'b1, "level flag after ack");
        @(posedge clk) x0_n <= 1;
        cyc(3);
        @(negedge clk);
        chk1(x0f, 1'b0, "level flag released");
        // Status, mask and interrupt line
        wr(`TMR_IDX_IRQ_STATUS, 32'h0);
        rdchk(`TMR_IDX_IRQ_STATUS, 32'h0c);
        @(negedge clk);
        chk1(irq, 1'b0, "masked irq");
        wr(`TMR_IDX_IRQ_MASK, 32'h04);
        rdchk(`TMR_IDX_IRQ_MASK, 32'h04);
        chk1(irq, 1'b1, "unmasked irq");
        wr(`TMR_IDX_IRQ_STATUS, 32'h04);
        rdchk(`TMR_IDX_IRQ_STATUS, 32'h08);
        chk1(irq, 1'b0, "irq after clear");
        print_verdict;
    end
endmodule : tb_top
